// ### rtl/adc_regbank_pkg.sv
// constants and types for the converter configuration register bank
// Function
// - register access is allowed only while the control style select input is low.
// - registers are read only by read command and written only by write command.
// - single and block access, consecutive bytes at ascending addresses.
// - address zero shows a fixed identity nibble in bits 7:4; writes never change it.
// - high-pass corner is a 16-bit word, low byte 03h, high byte 04h.
// - high-pass corner resets to 32h low byte and 03h high byte.
// - offset correction is 24 bits over bytes 05h, 06h and 07h.
// - all offset correction bytes reset to 00h.
// - gain correction is 24 bits over 08h to 0Ah, high byte resets 40h.
package adc_regbank_pkg;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [4:0] ADDR_IDENTITY = 5'h00;
    localparam logic [4:0] ADDR_MAIN_SETUP = 5'h01;
    localparam logic [4:0] ADDR_RESERVED = 5'h02;
    localparam logic [4:0] ADDR_CORNER_LOW = 5'h03;
    localparam logic [4:0] ADDR_CORNER_HIGH = 5'h04;
    localparam logic [4:0] ADDR_OFFSET_LOW = 5'h05;
    localparam logic [4:0] ADDR_OFFSET_MID = 5'h06;
    localparam logic [4:0] ADDR_OFFSET_HIGH = 5'h07;
    localparam logic [4:0] ADDR_GAIN_LOW = 5'h08;
    localparam logic [4:0] ADDR_GAIN_MID = 5'h09;
    localparam logic [4:0] ADDR_GAIN_HIGH = 5'h0a;
    localparam logic [4:0] ADDR_LAST = 5'h0a;
    localparam int NUM_REGS = 11;

    // ****************************************
    // reset values and fixed bits
    // ****************************************
    localparam logic [3:0] IDENT_BITS_DEFAULT = 4'h5; // arbitrary value
    localparam logic [7:0] RST_MAIN_SETUP = 8'h52;
    localparam logic [7:0] RST_RESERVED = 8'h08;
    localparam logic [7:0] RST_CORNER_LOW = 8'h32;
    localparam logic [7:0] RST_CORNER_HIGH = 8'h03;
    localparam logic [7:0] RST_OFFSET_BYTE = 8'h00;
    localparam logic [7:0] RST_GAIN_LOW = 8'h00;
    localparam logic [7:0] RST_GAIN_MID = 8'h00;
    localparam logic [7:0] RST_GAIN_HIGH = 8'h40;
    localparam logic [7:0] MAIN_SETUP_FIXED_MASK = 8'h40;

    // ****************************************
    // main setup fields
    // ****************************************
    localparam int SYNC_MODE_BIT = 7;
    localparam int RATE_MSB = 5;
    localparam int RATE_LSB = 3;
    localparam int PHASE_BIT = 2;
    localparam int FILTER_MSB = 1;
    localparam int FILTER_LSB = 0;

    // ****************************************
    // carrier types
    // ****************************************
    typedef enum logic {SYNC_PULSE, SYNC_CONTINUOUS} sync_mode_t;

    typedef struct packed {
        sync_mode_t syncMode;
        logic [2:0] outputRateSel;
        logic firResponseSel;
        logic [1:0] filterPathSel;
        logic [15:0] highpassCorner;
        logic [23:0] offsetCorrWord;
        logic [23:0] gainCorrWord;
    } setup_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] addr;
        logic [7:0] data;
    } reg_req_t;

endpackage

// ### rtl/adc_reg_byte.sv
// one writable configuration byte with its own reset value
`timescale 1ns/1ns
module adc_reg_byte #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] FIXED_MASK = 8'h00
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic writeEn,
    input wire logic [7:0] writeData,
    output logic [7:0] value
);

    logic [7:0] value_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            value_reg <= RESET_VALUE;
        end else if (writeEn) begin
            // fixed bits keep their reset value
            value_reg <= (writeData & ~FIXED_MASK) | (RESET_VALUE & FIXED_MASK);
        end
    end

    assign value = value_reg;

endmodule

// ### rtl/adc_config_register_bank.sv
// configuration register bank reached by read and write register commands
`timescale 1ns/1ns
module adc_config_register_bank (
    input wire logic clk,
    input wire logic resetn,
    input wire logic controlStyleSelect,
    input wire logic cmdStart,
    input wire logic cmdWrite,
    input wire logic [4:0] cmdStartAddr,
    input wire logic [4:0] cmdCount,
    input wire logic byteStrobe,
    input wire logic [7:0] writeByte,
    output logic [7:0] readByte,
    output logic readValid,
    output logic cmdBusy,
    output logic accessRefused,
    output adc_regbank_pkg::setup_t setup
);

    // ****************************************
    // pin synchroniser
    // ****************************************
    logic styleMeta_reg;
    logic styleSync_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            styleMeta_reg <= 1'b1;
            styleSync_reg <= 1'b1;
        end else begin
            styleMeta_reg <= controlStyleSelect;
            styleSync_reg <= styleMeta_reg;
        end
    end

    wire logic regMode = !styleSync_reg;

    // ****************************************
    // command sequencer
    // ****************************************
    typedef enum logic {IDLE, XFER} seq_state_t;
    seq_state_t state_reg;
    logic write_reg;
    logic [4:0] addr_reg;
    logic [5:0] remain_reg;
    logic [7:0] readByte_reg;
    logic readValid_reg;
    logic refused_reg;

    wire logic startOk = cmdStart && regMode;
    wire logic xferByte = (state_reg == XFER) && byteStrobe;
    wire logic lastByte = xferByte && (remain_reg == 6'h01);
    wire logic doWrite = xferByte && write_reg;
    wire logic doRead = xferByte && !write_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= IDLE;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    if (startOk) begin
                        state_reg <= XFER;
                    end
                end
                XFER: begin
                    if (lastByte || !regMode) begin
                        state_reg <= IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            write_reg <= 1'b0;
            addr_reg <= 5'h00;
            remain_reg <= 6'h00;
        end else if (state_reg == IDLE && startOk) begin
            write_reg <= cmdWrite;
            addr_reg <= cmdStartAddr;
            remain_reg <= {1'b0, cmdCount} + 6'h01;
        end else if (xferByte) begin
            addr_reg <= addr_reg + 5'h01;
            remain_reg <= remain_reg - 6'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            refused_reg <= 1'b0;
        end else begin
            refused_reg <= cmdStart && !startOk;
        end
    end

    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] regValue [adc_regbank_pkg::NUM_REGS];
    localparam logic [7:0] RESET_TABLE [adc_regbank_pkg::NUM_REGS] = '{
        8'h00, adc_regbank_pkg::RST_MAIN_SETUP, adc_regbank_pkg::RST_RESERVED,
        adc_regbank_pkg::RST_CORNER_LOW, adc_regbank_pkg::RST_CORNER_HIGH,
        adc_regbank_pkg::RST_OFFSET_BYTE, adc_regbank_pkg::RST_OFFSET_BYTE, adc_regbank_pkg::RST_OFFSET_BYTE,
        adc_regbank_pkg::RST_GAIN_LOW, adc_regbank_pkg::RST_GAIN_MID, adc_regbank_pkg::RST_GAIN_HIGH};

    // identity byte: fixed nibble, low nibble reads zero
    assign regValue[0] = {adc_regbank_pkg::IDENT_BITS_DEFAULT, 4'h0};

    genvar gi;
    generate
        for (gi = 1; gi < adc_regbank_pkg::NUM_REGS; gi++) begin : g_byte
            adc_reg_byte #(
                .RESET_VALUE(RESET_TABLE[gi]),
                // reserved byte ignores writes and keeps its reset value
                .FIXED_MASK(gi == 1 ? adc_regbank_pkg::MAIN_SETUP_FIXED_MASK :
                    (gi == 2 ? 8'hff : 8'h00))
            ) u_byte (
                .clk(clk),
                .resetn(resetn),
                .writeEn(doWrite && addr_reg == 5'(gi)),
                .writeData(writeByte),
                .value(regValue[gi])
            );
        end
    endgenerate

    // ****************************************
    // read path
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readByte_reg <= 8'h00;
            readValid_reg <= 1'b0;
        end else begin
            readValid_reg <= doRead;
            if (doRead) begin
                readByte_reg <= (addr_reg <= adc_regbank_pkg::ADDR_LAST) ?
                    regValue[addr_reg[3:0]] : 8'h00;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign readByte = readByte_reg;
    assign readValid = readValid_reg;
    assign cmdBusy = (state_reg == XFER);
    assign accessRefused = refused_reg;

    assign setup.syncMode = adc_regbank_pkg::sync_mode_t'(regValue[1][adc_regbank_pkg::SYNC_MODE_BIT]);
    assign setup.outputRateSel = regValue[1][adc_regbank_pkg::RATE_MSB:adc_regbank_pkg::RATE_LSB];
    assign setup.firResponseSel = regValue[1][adc_regbank_pkg::PHASE_BIT];
    assign setup.filterPathSel = regValue[1][adc_regbank_pkg::FILTER_MSB:adc_regbank_pkg::FILTER_LSB];
    assign setup.highpassCorner = {regValue[4], regValue[3]};
    assign setup.offsetCorrWord = {regValue[7], regValue[6], regValue[5]};
    assign setup.gainCorrWord = {regValue[10], regValue[9], regValue[8]};

    // ****************************************
    // assertions
    // ****************************************
    sequence s_start;
        state_reg == IDLE && startOk;
    endsequence

    sequence s_read_strobe;
        doRead;
    endsequence

    sequence s_last_byte;
        lastByte;
    endsequence

    a_refuse_pin: assert property (@(posedge clk) disable iff (!resetn)
        cmdStart && styleSync_reg |=> accessRefused && $stable(state_reg))
        else $error("access taken in pin control style");
    a_refuse_once: assert property (@(posedge clk) disable iff (!resetn)
        !cmdStart |=> !accessRefused)
        else $error("refusal without a command");
    a_abort_pin: assert property (@(posedge clk) disable iff (!resetn)
        cmdBusy && styleSync_reg |=> !cmdBusy)
        else $error("transfer kept in pin control style");
    a_start_busy: assert property (@(posedge clk) disable iff (!resetn)
        s_start |=> cmdBusy)
        else $error("accepted command not busy");
    a_ident_fixed: assert property (@(posedge clk) disable iff (!resetn)
        doRead && addr_reg == 5'h00 |=> readByte[7:4] == adc_regbank_pkg::IDENT_BITS_DEFAULT)
        else $error("identity nibble wrong");
    a_addr_step: assert property (@(posedge clk) disable iff (!resetn)
        xferByte && !lastByte && regMode |=> addr_reg == $past(addr_reg) + 5'h01)
        else $error("block address did not ascend");
    a_block_end: assert property (@(posedge clk) disable iff (!resetn)
        s_last_byte |=> !cmdBusy)
        else $error("busy after last byte");
    a_count_len: assert property (@(posedge clk) disable iff (!resetn)
        s_start |=> remain_reg == 6'($past(cmdCount)) + 6'h01)
        else $error("byte count not count plus one");
    a_read_pulse: assert property (@(posedge clk) disable iff (!resetn)
        s_read_strobe |=> readValid)
        else $error("read byte not answered");
    a_read_only: assert property (@(posedge clk) disable iff (!resetn)
        !doRead |=> !readValid)
        else $error("read answer without read strobe");
    a_write_corner: assert property (@(posedge clk) disable iff (!resetn)
        doWrite && addr_reg == adc_regbank_pkg::ADDR_CORNER_HIGH |=> setup.highpassCorner[15:8] == $past(writeByte))
        else $error("corner high byte not written");
    a_corner_low_write: assert property (@(posedge clk) disable iff (!resetn)
        doWrite && addr_reg == adc_regbank_pkg::ADDR_CORNER_LOW |=> setup.highpassCorner[7:0] == $past(writeByte))
        else $error("corner low byte not written");
    a_write_only: assert property (@(posedge clk) disable iff (!resetn)
        !doWrite |=> $stable(setup))
        else $error("setup changed without write");
    a_setup_fixed: assert property (@(posedge clk) disable iff (!resetn)
        regValue[1][6] == 1'b1)
        else $error("fixed setup bit lost");
    a_offset_write: assert property (@(posedge clk) disable iff (!resetn)
        doWrite && addr_reg == adc_regbank_pkg::ADDR_OFFSET_LOW |=> setup.offsetCorrWord[7:0] == $past(writeByte))
        else $error("offset low byte not written");
    a_offset_high_write: assert property (@(posedge clk) disable iff (!resetn)
        doWrite && addr_reg == adc_regbank_pkg::ADDR_OFFSET_HIGH |=> setup.offsetCorrWord[23:16] == $past(writeByte))
        else $error("offset high byte not written");
    a_gain_write: assert property (@(posedge clk) disable iff (!resetn)
        doWrite && addr_reg == adc_regbank_pkg::ADDR_GAIN_HIGH |=> setup.gainCorrWord[23:16] == $past(writeByte))
        else $error("gain high byte not written");
    a_gain_low_write: assert property (@(posedge clk) disable iff (!resetn)
        doWrite && addr_reg == adc_regbank_pkg::ADDR_GAIN_LOW |=> setup.gainCorrWord[7:0] == $past(writeByte))
        else $error("gain low byte not written");

endmodule

// ### sim/adc_host_model.sv
// host controller model issuing register commands
`timescale 1ns/1ns
module adc_host_model (
    input wire logic clk,
    input wire logic [7:0] readByte,
    input wire logic readValid,
    output logic controlStyleSelect,
    output logic cmdStart,
    output logic cmdWrite,
    output logic [4:0] cmdStartAddr,
    output logic [4:0] cmdCount,
    output logic byteStrobe,
    output logic [7:0] writeByte
);
    logic streamStopped = 1'b0;
    initial begin
        controlStyleSelect = 1'b1;
        {cmdStart, cmdWrite, cmdStartAddr, cmdCount, byteStrobe, writeByte} = '0;
    end
    task automatic set_style(input logic s);
        @(negedge clk);
        controlStyleSelect = s;
    endtask
    task automatic begin_cmd(input logic wr, input logic [4:0] addr, input int n);
        @(negedge clk);
        {cmdStart, cmdWrite, cmdStartAddr} = {1'b1, wr, addr};
        cmdCount = 5'(n - 1);
        @(negedge clk);
        cmdStart = 1'b0;
        cmdStartAddr = ~addr;
    endtask
    task automatic write_regs(input logic [4:0] addr, input logic [7:0] q[$]);
        begin_cmd(1'b1, addr, q.size());
        foreach (q[i]) begin
            byteStrobe = 1'b1;
            writeByte = q[i];
            @(negedge clk);
        end
        byteStrobe = 1'b0;
        // released data line shows the inverse, never a stale value
        writeByte = ~writeByte;
    endtask
    task automatic read_regs(input logic [4:0] addr, input int n, output logic [7:0] q[$], output logic ok);
        int k;
        streamStopped = 1'b1;
        begin_cmd(1'b0, addr, n);
        q = {};
        ok = 1'b1;
        repeat (n) begin
            byteStrobe = 1'b1;
            @(negedge clk);
            byteStrobe = 1'b0;
            k = 0;
            while (readValid !== 1'b1 && k < 4) begin
                @(negedge clk);
                k++;
            end
            ok = ok & (readValid === 1'b1);
            q.push_back(readByte);
            @(negedge clk);
        end
    endtask
endmodule

// ### sim/tb_top.sv
// top-level testbench for the configuration register bank
`timescale 1ns/1ns
module tb_top;
    localparam logic [7:0] ID_BYTE = {adc_regbank_pkg::IDENT_BITS_DEFAULT, 4'h0};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic styleSel, cmdStart, cmdWrite, byteStrobe, readValid, cmdBusy, accessRefused, ok;
    logic [4:0] cmdStartAddr, cmdCount;
    logic [7:0] writeByte, readByte;
    logic [7:0] rd[$];
    adc_regbank_pkg::setup_t setup;
    int errors = 0;
    int checks = 0;
    int refusedSeen = 0;
    always #10 clk = ~clk;
    always @(posedge clk) if (accessRefused === 1'b1) refusedSeen++;
    adc_config_register_bank dut_u (.clk(clk), .resetn(resetn), .controlStyleSelect(styleSel),
        .cmdStart(cmdStart), .cmdWrite(cmdWrite), .cmdStartAddr(cmdStartAddr), .cmdCount(cmdCount),
        .byteStrobe(byteStrobe), .writeByte(writeByte), .readByte(readByte), .readValid(readValid),
        .cmdBusy(cmdBusy), .accessRefused(accessRefused), .setup(setup));
    adc_host_model host_u (.clk(clk), .readByte(readByte), .readValid(readValid),
        .controlStyleSelect(styleSel), .cmdStart(cmdStart), .cmdWrite(cmdWrite),
        .cmdStartAddr(cmdStartAddr), .cmdCount(cmdCount), .byteStrobe(byteStrobe), .writeByte(writeByte));
    function automatic adc_regbank_pkg::setup_t mk(input logic [7:0] m, input logic [15:0] h,
        input logic [23:0] o, input logic [23:0] g);
        return {m[7], m[5:3], m[2], m[1:0], h, o, g};
    endfunction
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            errors++;
            $display("Error at %0t: byte %h expected %h", $time, got, want);
        end
    endtask
    task automatic check_setup(input adc_regbank_pkg::setup_t want);
        checks++;
        if (setup !== want) begin
            errors++;
            $display("Error at %0t: setup %h expected %h", $time, setup, want);
        end
    endtask
    task automatic read_check(input logic [4:0] addr, input logic [7:0] want[$]);
        host_u.read_regs(addr, want.size(), rd, ok);
        if (ok !== 1'b1) begin
            errors++;
            $display("Error at %0t: read data never came", $time);
            complete_run();
        end else begin
            foreach (want[i]) check8(rd[i], want[i]);
        end
    endtask
    initial begin
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        host_u.set_style(1'b0);
        repeat (4) @(negedge clk);
        check_setup(mk(8'h52, 16'h0332, 24'h000000, 24'h400000));
        read_check(5'h00, {ID_BYTE, 8'h52, 8'h08, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h40});
        $display("test reset values done");
        host_u.write_regs(5'h00, {8'hff, 8'h8d, 8'h77, 8'ha5, 8'h5a, 8'h11, 8'h22, 8'h33,
            8'h44, 8'h55, 8'h66});
        repeat (2) @(negedge clk);
        check_setup(mk(8'hcd, 16'h5aa5, 24'h332211, 24'h665544));
        read_check(5'h00, {ID_BYTE, 8'hcd, 8'h08, 8'ha5, 8'h5a, 8'h11, 8'h22, 8'h33,
            8'h44, 8'h55, 8'h66});
        $display("test block write done");
        host_u.write_regs(5'h09, {8'h99});
        host_u.write_regs(5'h01, {8'h00});
        read_check(5'h09, {8'h99});
        read_check(5'h01, {8'h40});
        read_check(5'h0a, {8'h66, 8'h00});
        $display("test single access done");
        host_u.begin_cmd(1'b1, 5'h05, 1);
        check8({7'h00, cmdBusy}, 8'h01);
        host_u.set_style(1'b1);
        repeat (3) @(negedge clk);
        check8({7'h00, cmdBusy}, 8'h00);
        host_u.begin_cmd(1'b1, 5'h03, 1);
        repeat (3) @(negedge clk);
        check8(8'(refusedSeen), 8'h01);
        check8({7'h00, cmdBusy}, 8'h00);
        host_u.set_style(1'b0);
        repeat (4) @(negedge clk);
        read_check(5'h03, {8'ha5, 8'h5a, 8'h11});
        $display("test refused access done");
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        check_setup(mk(8'h52, 16'h0332, 24'h000000, 24'h400000));
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        check8({readValid, accessRefused, cmdBusy, 5'h00}, 8'h00);
        read_check(5'h01, {8'h52, 8'h08, 8'h32});
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
